// ===== core/sipo_latch_defines.svh
// Constants for the serial-in parallel-out latch
`ifndef SIPO_LATCH_DEFINES_SVH
`define SIPO_LATCH_DEFINES_SVH
`define SIPO_WIDTH       8
`define SIPO_SHIFT_RESET 8'h00
`define SIPO_LAST_STAGE  7
`define SIPO_LINK_HALF   4
`endif

// ===== core/sipo_latch_pkg.sv
// Types shared by the serial-in parallel-out latch
`default_nettype none
package sipo_latch_pkg;
    // Synchronised pin levels, sampled together on the system clock
    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic shift_clear_n;
        logic storage_clock;
        logic output_enable_n;
    } pins_type;
    // Edge state of a sampled link clock
    typedef enum logic [1:0] {
        CLK_LOW  = 2'b00,
        CLK_RISE = 2'b01,
        CLK_HIGH = 2'b10,
        CLK_FALL = 2'b11
    } edge_state_type;
endpackage
`default_nettype wire

// ===== core/pin_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    input  wire logic i_pin,
    output logic      o_level
);
    logic meta_q;
    logic meta_d;
    logic level_q;
    logic level_d;

    // ==========================================
    // Next values: first flop feeds only the second
    always_comb begin
        meta_d  = i_pin;
        level_d = meta_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q  <= meta_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule
`default_nettype wire

// ===== core/sipo_latch.sv
// Serial-in shift register feeding a storage register with gated outputs
`timescale 1ns/1ps
`default_nettype none
`include "sipo_latch_defines.svh"
module sipo_latch (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_arst_n,
    input  wire logic                    i_serial_in,
    input  wire logic                    i_shift_clock,
    input  wire logic                    i_shift_clear_n,
    input  wire logic                    i_storage_clock,
    input  wire logic                    i_output_enable_n,
    output logic [`SIPO_WIDTH-1:0]       o_parallel_out,
    output logic [`SIPO_WIDTH-1:0]       o_parallel_out_oe_n,
    output logic                         o_cascade_out
);
    // Synchronised pin levels, one flop pair per pin
    logic                     data_sync;
    logic                     shift_sync;
    logic                     clear_sync;
    logic                     store_sync;
    logic                     enable_sync;
    // The same levels as one carrier, read by all logic below
    sipo_latch_pkg::pins_type pins;
    logic                     shift_clk_q;
    logic                     shift_clk_d;
    logic                     store_clk_q;
    logic                     store_clk_d;
    logic [`SIPO_WIDTH-1:0]   shift_q;
    logic [`SIPO_WIDTH-1:0]   shift_d;
    logic [`SIPO_WIDTH-1:0]   store_q;
    logic [`SIPO_WIDTH-1:0]   store_d;
    logic [`SIPO_WIDTH-1:0]   out_q;
    logic [`SIPO_WIDTH-1:0]   out_d;
    logic [`SIPO_WIDTH-1:0]   oe_n_q;
    logic [`SIPO_WIDTH-1:0]   oe_n_d;
    logic                     shift_rise;
    logic                     store_rise;

    // ==========================================
    // Pin synchronisers: every pin is asynchronous to the system clock.
    // All five pass the same two flops, so data and clocks stay aligned
    // and the serial level still meets its setup at the detected edge.
    pin_sync u_sync_data (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_serial_in),
        .o_level   (data_sync)
    );
    pin_sync u_sync_shift (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_shift_clock),
        .o_level   (shift_sync)
    );
    pin_sync u_sync_clear (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_shift_clear_n),
        .o_level   (clear_sync)
    );
    pin_sync u_sync_store (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_storage_clock),
        .o_level   (store_sync)
    );
    // The enable goes through inverted: the flops reset to zero, which then
    // reads as floated outputs, so no drive glitch follows a reset
    pin_sync u_sync_enable (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_pin     (~i_output_enable_n),
        .o_level   (enable_sync)
    );
    // Gather the levels; the enable is turned back to active low here
    assign pins = {data_sync, shift_sync, clear_sync, store_sync, ~enable_sync};

    // ==========================================
    // Edge finders on the synchronised clocks
    assign shift_rise = pins.shift_clock & ~shift_clk_q;
    assign store_rise = pins.storage_clock & ~store_clk_q;

    // ==========================================
    // Next state of both registers
    always_comb begin
        shift_clk_d = pins.shift_clock;
        store_clk_d = pins.storage_clock;
        shift_d     = shift_q;
        store_d     = store_q;
        // Store takes the old shift value, so shared clocks give a one-pulse lag
        if (store_rise) begin
            store_d = shift_q;
        end
        if (!pins.shift_clear_n) begin
            shift_d = `SIPO_SHIFT_RESET;
        end else if (shift_rise) begin
            shift_d = {shift_q[`SIPO_WIDTH-2:0], pins.serial_in};
        end
        // Enable low drives pins; high floats them, cascade unaffected
        oe_n_d = {`SIPO_WIDTH{pins.output_enable_n}};
        out_d  = store_d;
    end

    // Reset value is only a simulation convenience; a controller must not rely on it
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_clk_q <= 1'b0;
            store_clk_q <= 1'b0;
            shift_q     <= `SIPO_SHIFT_RESET;
            store_q     <= `SIPO_SHIFT_RESET;
            out_q       <= `SIPO_SHIFT_RESET;
            oe_n_q      <= {`SIPO_WIDTH{1'b1}};
        end else begin
            shift_clk_q <= shift_clk_d;
            store_clk_q <= store_clk_d;
            shift_q     <= shift_d;
            store_q     <= store_d;
            out_q       <= out_d;
            oe_n_q      <= oe_n_d;
        end
    end

    // ==========================================
    // Outputs
    // Parallel data comes from its own flop, a copy of the storage register,
    // so the pins see no combinational path from the clock edge finders
    assign o_parallel_out      = out_q;
    assign o_parallel_out_oe_n = oe_n_q;
    assign o_cascade_out       = shift_q[`SIPO_LAST_STAGE];

    // ==========================================
    // Checks
    // Every register here moves on the system edge after the detected pin
    // edge, so each check looks one edge after its cause. The reset value
    // is outside the rules and is left to the bench.
    chk_shift_step: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (shift_rise && pins.shift_clear_n) |=>
            shift_q == {$past(shift_q[`SIPO_WIDTH-2:0]), $past(pins.serial_in)})
        else $error("shift step wrong");

    chk_shift_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!shift_rise && pins.shift_clear_n) |=> $stable(shift_q))
        else $error("stages moved without a shift edge");

    chk_first_stage: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (shift_rise && pins.shift_clear_n) |=> shift_q[0] == $past(pins.serial_in))
        else $error("first stage missed serial level");

    chk_clear_zero: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !pins.shift_clear_n |=> shift_q == 8'h00)
        else $error("clear did not zero stages");

    chk_store_no_clear: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!pins.shift_clear_n && !store_rise) |=> $stable(store_q))
        else $error("clear disturbed the storage register");

    chk_store_copy: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        store_rise |=> store_q == $past(shift_q))
        else $error("storage copy wrong");

    chk_store_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !store_rise |=> $stable(store_q))
        else $error("storage changed without clock");

    chk_float_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        pins.output_enable_n |=> o_parallel_out_oe_n == 8'hFF)
        else $error("outputs not floated");

    chk_drive_out: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !pins.output_enable_n |=> o_parallel_out_oe_n == 8'h00 && o_parallel_out == store_q)
        else $error("outputs not driven");

    chk_out_stable: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !store_rise |=> $stable(o_parallel_out))
        else $error("parallel data changed without storage edge");

    chk_clear_wins: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!pins.shift_clear_n && shift_rise) |=> shift_q == 8'h00)
        else $error("shift beat clear");

    chk_tied_lag: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (shift_rise && store_rise && pins.shift_clear_n) |=> store_q == $past(shift_q)
            && shift_q[`SIPO_WIDTH-1:1] == $past(shift_q[`SIPO_WIDTH-2:0]))
        else $error("storage not one pulse behind");

    chk_cascade_bit: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (shift_rise && pins.shift_clear_n) |=>
            o_cascade_out == $past(shift_q[`SIPO_LAST_STAGE-1]))
        else $error("cascade not eighth stage");

    chk_cascade_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!shift_rise && pins.shift_clear_n) |=> $stable(o_cascade_out))
        else $error("cascade moved without a shift edge");

    chk_cascade_clear: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !pins.shift_clear_n |=> !o_cascade_out)
        else $error("cascade not cleared");
endmodule
`default_nettype wire

// ===== bench/pin_driver.sv
// Behavioural controller model that drives the latch pins
`timescale 1ns/1ps
`default_nettype none
`include "sipo_latch_defines.svh"
module pin_driver (
    input  wire logic                     i_clk_sys,
    output var  sipo_latch_pkg::pins_type o_pins
);
    // ==========================================
    // Pin levels
    localparam int HALF = `SIPO_LINK_HALF; // 320 ns link period at a 40 ns system clock
    // Start cleared and floated, so nothing is trusted before a load
    initial o_pins = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    // One link clock pulse of two half periods; clocks stand still between pulses
    task automatic pulse(input logic sh, input logic st, input logic bit_v);
        @(posedge i_clk_sys) o_pins.serial_in <= bit_v;
        repeat (HALF - 1) @(posedge i_clk_sys);
        o_pins.shift_clock <= sh;
        o_pins.storage_clock <= st;
        repeat (HALF) @(posedge i_clk_sys);
        o_pins.shift_clock <= 1'b0;
        o_pins.storage_clock <= 1'b0;
        o_pins.serial_in <= ~bit_v; // Hold is over, so show the inverse
    endtask
    // Clear and enable levels, then time for them to be seen
    task automatic set_lvl(input logic clr_n, input logic en_n);
        @(posedge i_clk_sys) o_pins.shift_clear_n <= clr_n;
        o_pins.output_enable_n <= en_n;
        repeat (HALF) @(posedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_serial_in_parallel_out_latch.sv
// Self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
`default_nettype none
`include "sipo_latch_defines.svh"
module tb_serial_in_parallel_out_latch;
    // ==========================================
    // Wiring
    logic                     clk_sys = 1'b0;
    logic                     arst_n = 1'b0;
    sipo_latch_pkg::pins_type pins;
    logic [`SIPO_WIDTH-1:0]   par;
    logic [`SIPO_WIDTH-1:0]   oe_n;
    logic                     casc;
    int                       fails = 0;
    int                       n_tests = 0;
    always #20 clk_sys = ~clk_sys;
    pin_driver drv_u (.i_clk_sys(clk_sys), .o_pins(pins));
    sipo_latch dut_u (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_serial_in(pins.serial_in),
        .i_shift_clock(pins.shift_clock), .i_shift_clear_n(pins.shift_clear_n),
        .i_storage_clock(pins.storage_clock), .i_output_enable_n(pins.output_enable_n),
        .o_parallel_out(par), .o_parallel_out_oe_n(oe_n), .o_cascade_out(casc));
    // ==========================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Most significant bit first, so it ends in the last stage
    task automatic load(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) drv_u.pulse(1'b1, 1'b0, v[i]);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_shift();
        drv_u.set_lvl(1'b1, 1'b1);
        load(8'hA5);
        #1 chk({7'h00, casc}, 8'h01);
        drv_u.pulse(1'b0, 1'b1, 1'b0);
        drv_u.set_lvl(1'b1, 1'b0);
        #1 chk(par, 8'hA5);
        chk(oe_n, 8'h00);
        $display("test shift done");
    endtask
    // Shared clocks: the store sees the stages from before the edge
    task automatic t_tied();
        drv_u.pulse(1'b1, 1'b1, 1'b0);
        #1 chk(par, 8'hA5);
        drv_u.pulse(1'b0, 1'b1, 1'b0);
        #1 chk(par, 8'h4A);
        $display("test tied done");
    endtask
    // Shift edges during clear must lose; the store then copies zeros
    task automatic t_clear();
        load(8'hFF);
        drv_u.set_lvl(1'b0, 1'b0);
        drv_u.pulse(1'b1, 1'b1, 1'b1);
        #1 chk(par, 8'h00);
        chk({7'h00, casc}, 8'h00);
        drv_u.set_lvl(1'b1, 1'b1);
        load(8'h80);
        #1 chk(oe_n, 8'hFF);
        chk({7'h00, casc}, 8'h01);
        chk(par, 8'h00);
        $display("test clear done");
    endtask
    // Mid-run reset floats the outputs and zeroes both registers
    task automatic t_reset();
        drv_u.set_lvl(1'b1, 1'b0);
        drv_u.pulse(1'b0, 1'b1, 1'b0);
        #1 chk(par, 8'h80);
        @(posedge clk_sys) arst_n <= 1'b0;
        #1 chk(oe_n, 8'hFF);
        chk(par, 8'h00);
        chk({7'h00, casc}, 8'h00);
        @(posedge clk_sys) arst_n <= 1'b1;
        drv_u.set_lvl(1'b1, 1'b0);
        #1 chk(oe_n, 8'h00);
        chk(par, 8'h00);
        $display("test reset done");
    endtask
    // ==========================================
    // Run control
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_shift();
        t_tied();
        t_clear();
        t_reset();
        stop_test();
    end
    // Watchdog against a hung scenario
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
